// file: src/cfp_core.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
module cfp_core
  import cfp_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [1:0] RESET_CAUSE,
  input wire logic LOW_VOLT_HIGH_OPTION,
  input wire logic LOW_VOLT_MID_OPTION,
  input wire logic SUPPLY_BELOW_HIGH,
  input wire logic SUPPLY_BELOW_MID,
  output logic [15:0] INDIRECT_ADDR,
  output logic [9:0] FETCH_ADDR,
  output logic [9:0] ROM_ADDR
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic [9:0] pc;
    logic [7:0] acc;
    logic [7:0] flags;
    logic [7:0] acc_save;
    logic [7:0] flags_save;
    logic [7:0] lookup;
    logic [7:0] offset_ptr;
    logic [7:0] page_ptr;
    logic [7:0] operand;
    logic [9:0] jump_target;
    logic [15:0] rom_word;
    logic cause_taken;
    logic boot;
  } cfp_state_t;

  cfp_state_t cur;
  cfp_state_t nxt;
  logic [7:0] alu_result;
  logic alu_wrap;
  logic alu_nibble;
  logic alu_null;
  logic alu_skip;
  logic [9:0] next_pc;
  logic [8:0] pcl_sum;
  logic [7:0] pcl_diff;

  // APB word index of a byte address
  function automatic logic [7:0] word_index(input logic [11:0] addr);
    word_index = addr[9:2];
  endfunction : word_index

  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr[1:0] == 2'b00) && (addr[11:10] == 2'b00) && (word_index(addr) == idx);
  endfunction : hit

  wire logic access = PSEL & PENABLE & ~cur.ready;
  // Misaligned or out-of-window addresses are refused outright
  wire logic aligned = (PADDR[1:0] == 2'b00) && (PADDR[11:10] == 2'b00);
  wire logic wr = access & PWRITE & PSTRB[0];
  wire logic [7:0] wbyte = PWDATA[7:0];
  // Control word: [4:0] op, [5] use carry, [6] rotate-out bit, [7] tested bit
  wire cfp_op_t ctrl_op = cfp_op_t'(PWDATA[4:0]);
  wire logic ctrl_go = wr && hit(PADDR, CFP_IDX_CTRL);
  // Memory forms count the operand byte, so the accumulator must not feed them
  wire logic mem_form = (ctrl_op == CFP_OP_INC_MEM_SKIP) || (ctrl_op == CFP_OP_DEC_MEM_SKIP);

  cfp_alu_flags u_alu (
    .op(ctrl_go ? ctrl_op : CFP_OP_NONE),
    .lhs(mem_form ? cur.operand : cur.acc),
    .rhs(cur.operand),
    .carry_in(cur.flags[CFP_F_WRAP]),
    .use_carry(PWDATA[5]),
    .rot_out(PWDATA[6]),
    .test_bit(PWDATA[7]),
    .result(alu_result),
    .wrap(alu_wrap),
    .nibble(alu_nibble),
    .null_res(alu_null),
    .skip(alu_skip)
  );

  // Low-byte arithmetic on the counter for computed jumps
  assign pcl_sum = {1'b0, cur.pc[7:0]} + {1'b0, cur.acc};
  assign pcl_diff = cur.pc[7:0] - cur.acc;

  wire logic low_add = ctrl_go && (ctrl_op == CFP_OP_ADD) && PWDATA[8];
  wire logic low_sub = ctrl_go && (ctrl_op == CFP_OP_SUB) && PWDATA[8];
  wire logic low_plain = wr && hit(PADDR, CFP_IDX_PC_LOW);

  cfp_pc_unit u_pc (
    .pc(cur.pc),
    .advance(ctrl_go && (ctrl_op != CFP_OP_JUMP) && !low_add && !low_sub),
    .jump(ctrl_go && (ctrl_op == CFP_OP_JUMP)),
    .target(cur.jump_target),
    .skip(alu_skip),
    .low_write(low_plain | low_add | low_sub),
    .low_value(low_add ? pcl_sum[7:0] : (low_sub ? pcl_diff : wbyte)),
    .low_add(low_add),
    .low_carry(pcl_sum[8]),
    .next_pc(next_pc)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt = cur;
    nxt.ready = access;
    nxt.slverr = 1'b0;
    nxt.rdata = 32'h0000_0000;
    nxt.boot = 1'b0;
    // Cause bits are captured once after reset release, never under reset
    if (!cur.cause_taken) begin
      nxt.flags[CFP_F_CAUSE_HI] = RESET_CAUSE[1];
      nxt.flags[CFP_F_CAUSE_LO] = RESET_CAUSE[0];
      nxt.cause_taken = 1'b1;
    end
    // Brownout flags are live views gated by the fitted option
    nxt.flags[CFP_F_BROWN_HI] = LOW_VOLT_HIGH_OPTION & SUPPLY_BELOW_HIGH;
    nxt.flags[CFP_F_BROWN_MID] = LOW_VOLT_MID_OPTION & SUPPLY_BELOW_MID;
    nxt.flags[3] = 1'b0;
    nxt.pc = next_pc;
    if (wr && !aligned) begin
      // A refused write must leave every register untouched
      nxt.slverr = 1'b1;
    end else if (wr) begin
      case (word_index(PADDR))
        CFP_IDX_LOOKUP: nxt.lookup = wbyte;
        CFP_IDX_OFFSET_PTR: nxt.offset_ptr = wbyte;
        CFP_IDX_PAGE_PTR: nxt.page_ptr = wbyte;
        CFP_IDX_FLAGS: begin
          nxt.flags[7:6] = wbyte[7:6];
          nxt.flags[2:0] = wbyte[2:0];
        end
        CFP_IDX_PC_HIGH: nxt.jump_target[9:8] = wbyte[1:0];
        CFP_IDX_ACC: nxt.acc = wbyte;
        CFP_IDX_OPERAND: nxt.operand = wbyte;
        CFP_IDX_ROM_ADDR: nxt.jump_target = PWDATA[9:0];
        CFP_IDX_ROM_DATA: nxt.rom_word = PWDATA[15:0];
        default: nxt.slverr = ~hit(PADDR, CFP_IDX_CTRL) & ~low_plain;
      endcase
    end
    if (ctrl_go) begin
      case (ctrl_op)
        CFP_OP_ADD, CFP_OP_SUB: begin
          if (!PWDATA[8]) begin
            nxt.acc = alu_result;
          end
          nxt.flags[CFP_F_WRAP] = alu_wrap;
          nxt.flags[CFP_F_NIBBLE] = alu_nibble;
          nxt.flags[CFP_F_NULL] = alu_null;
        end
        CFP_OP_CMP: begin
          nxt.flags[CFP_F_WRAP] = alu_wrap;
          nxt.flags[CFP_F_NULL] = alu_null;
        end
        CFP_OP_ROTATE: nxt.flags[CFP_F_WRAP] = alu_wrap;
        CFP_OP_LOGIC: begin
          nxt.acc = alu_result;
          nxt.flags[CFP_F_NULL] = alu_null;
        end
        CFP_OP_INC_ACC_SKIP, CFP_OP_DEC_ACC_SKIP: nxt.acc = alu_result;
        CFP_OP_INC_MEM_SKIP, CFP_OP_DEC_MEM_SKIP: nxt.operand = alu_result;
        CFP_OP_SAVE: begin
          nxt.acc_save = cur.acc;
          nxt.flags_save = cur.flags;
        end
        CFP_OP_RESTORE: begin
          nxt.acc = cur.acc_save;
          nxt.flags[7:6] = cur.flags_save[7:6];
          nxt.flags[2:0] = cur.flags_save[2:0];
        end
        CFP_OP_TABLE: begin
          nxt.lookup = cur.rom_word[15:8];
          nxt.acc = cur.rom_word[7:0];
        end
        CFP_OP_MOV_IMM: begin
          // Immediate data may only land in the working-register window
          if (cur.operand >= CFP_WREG_FIRST && cur.operand <= CFP_WREG_LAST) begin
            case (cur.operand)
              CFP_IDX_LOOKUP: nxt.lookup = PWDATA[23:16];
              CFP_IDX_OFFSET_PTR: nxt.offset_ptr = PWDATA[23:16];
              CFP_IDX_PAGE_PTR: nxt.page_ptr = PWDATA[23:16];
              default: nxt.slverr = 1'b0;
            endcase
          end else begin
            nxt.slverr = 1'b1;
          end
        end
        default: nxt.slverr = 1'b0;
      endcase
    end
    if (access && !PWRITE) begin
      case (word_index(PADDR))
        CFP_IDX_LOOKUP: nxt.rdata = {24'h00_0000, cur.lookup};
        CFP_IDX_OFFSET_PTR: nxt.rdata = {24'h00_0000, cur.offset_ptr};
        CFP_IDX_PAGE_PTR: nxt.rdata = {24'h00_0000, cur.page_ptr};
        CFP_IDX_FLAGS: nxt.rdata = {24'h00_0000, cur.flags};
        CFP_IDX_PC_LOW: nxt.rdata = {24'h00_0000, cur.pc[7:0]};
        CFP_IDX_PC_HIGH: nxt.rdata = {30'h0000_0000, cur.pc[9:8]};
        CFP_IDX_ACC: nxt.rdata = {24'h00_0000, cur.acc};
        CFP_IDX_OPERAND: nxt.rdata = {24'h00_0000, cur.operand};
        CFP_IDX_ROM_DATA: nxt.rdata = {16'h0000, cur.rom_word};
        default: nxt.slverr = 1'b1;
      endcase
      if (PADDR[1:0] != 2'b00 || PADDR[11:10] != 2'b00) begin
        nxt.slverr = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cur <= '0;
      cur.boot <= 1'b1;
    end else begin
      cur <= nxt;
    end
  end

  assign PRDATA = cur.rdata;
  assign PREADY = cur.ready;
  assign PSLVERR = cur.slverr;
  assign FETCH_ADDR = cur.pc;
  assign INDIRECT_ADDR = {cur.page_ptr, cur.offset_ptr};
  assign ROM_ADDR = {cur.page_ptr[1:0], cur.offset_ptr};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_plain_step;
    ctrl_go && ctrl_op == CFP_OP_STEP;
  endsequence

  // Steps that the flag and refusal checks below start from
  sequence s_add_plain;
    ctrl_go && ctrl_op == CFP_OP_ADD && !PWDATA[5];
  endsequence
  sequence s_sub_like;
    ctrl_go && (ctrl_op == CFP_OP_SUB || ctrl_op == CFP_OP_CMP);
  endsequence
  sequence s_restore;
    ctrl_go && ctrl_op == CFP_OP_RESTORE;
  endsequence
  // Immediate move aimed outside the working-register window
  sequence s_imm_outside;
    ctrl_go && ctrl_op == CFP_OP_MOV_IMM &&
      (cur.operand < CFP_WREG_FIRST || cur.operand > CFP_WREG_LAST);
  endsequence

  AST_RESET_PC: assert property (@(posedge CLK) SRST |=> cur.pc == CFP_PC_RST)
    else $error("Counter not cleared by reset");
  AST_STEP: assert property (@(posedge CLK) disable iff (SRST)
    s_plain_step |=> cur.pc == $past(cur.pc) + CFP_PC_STEP)
    else $error("Counter did not step by one");
  AST_JUMP: assert property (@(posedge CLK) disable iff (SRST)
    ctrl_go && ctrl_op == CFP_OP_JUMP |=> cur.pc == $past(cur.jump_target))
    else $error("Jump target not loaded");
  AST_SKIP: assert property (@(posedge CLK) disable iff (SRST)
    ctrl_go && alu_skip |=> cur.pc == $past(cur.pc) + CFP_PC_SKIP)
    else $error("Skip did not add two");
  AST_CMP_SKIP: assert property (@(posedge CLK) disable iff (SRST)
    ctrl_go && ctrl_op == CFP_OP_CMP_SKIP && cur.acc != cur.operand |-> !alu_skip)
    else $error("Compare skipped on unequal");
  AST_INC_SKIP: assert property (@(posedge CLK) disable iff (SRST)
    ctrl_go && ctrl_op == CFP_OP_INC_ACC_SKIP |-> alu_skip == (cur.acc == 8'hFF))
    else $error("Increment skip mismatch");
  AST_DEC_SKIP: assert property (@(posedge CLK) disable iff (SRST)
    ctrl_go && ctrl_op == CFP_OP_DEC_ACC_SKIP |=> (cur.acc == 8'hFF) == $past(alu_skip))
    else $error("Decrement skip mismatch");
  AST_CARRY_UP: assert property (@(posedge CLK) disable iff (SRST)
    low_add && pcl_sum[8] |=> cur.pc[9:8] == $past(cur.pc[9:8]) + 2'h1)
    else $error("Low byte carry not propagated");
  AST_NO_BORROW: assert property (@(posedge CLK) disable iff (SRST)
    (low_sub || low_plain) |=> cur.pc[9:8] == $past(cur.pc[9:8]))
    else $error("High part changed");
  AST_TABLE: assert property (@(posedge CLK) disable iff (SRST)
    ctrl_go && ctrl_op == CFP_OP_TABLE |=> {cur.lookup, cur.acc} == $past(cur.rom_word))
    else $error("Table read bytes wrong");
  AST_ZERO: assert property (@(posedge CLK) disable iff (SRST)
    ctrl_go && ctrl_op == CFP_OP_LOGIC |=> cur.flags[CFP_F_NULL] == (cur.acc == 8'h00))
    else $error("Zero flag wrong");
  AST_CAUSE: assert property (@(posedge CLK) disable iff (SRST)
    !cur.cause_taken |=> cur.flags[7:6] == $past(RESET_CAUSE))
    else $error("Reset cause not captured");
  AST_BROWN_HI: assert property (@(posedge CLK) disable iff (SRST)
    1'b1 |=> cur.flags[CFP_F_BROWN_HI] == $past(LOW_VOLT_HIGH_OPTION && SUPPLY_BELOW_HIGH))
    else $error("High brownout flag wrong");
  AST_BROWN_MID: assert property (@(posedge CLK) disable iff (SRST)
    1'b1 |=> cur.flags[CFP_F_BROWN_MID] == $past(LOW_VOLT_MID_OPTION && SUPPLY_BELOW_MID))
    else $error("Mid brownout flag wrong");
  AST_ADD_CARRY: assert property (@(posedge CLK) disable iff (SRST)
    s_add_plain |=> cur.flags[CFP_F_WRAP] == $past({1'b0, cur.acc} + {1'b0, cur.operand} > 9'h0FF))
    else $error("Add carry flag wrong");
  AST_ADD_HALF: assert property (@(posedge CLK) disable iff (SRST)
    s_add_plain |=> cur.flags[CFP_F_NIBBLE] == $past({1'b0, cur.acc[3:0]} + cur.operand[3:0] > 5'h0F))
    else $error("Add half carry flag wrong");
  AST_SUB_CARRY: assert property (@(posedge CLK) disable iff (SRST)
    s_sub_like |=> cur.flags[CFP_F_WRAP] == $past(cur.acc >= cur.operand))
    else $error("Subtract carry flag wrong");
  AST_MEM_SKIP: assert property (@(posedge CLK) disable iff (SRST)
    ctrl_go && mem_form |-> alu_skip ==
      (cur.operand == ((ctrl_op == CFP_OP_INC_MEM_SKIP) ? 8'hFF : 8'h00)))
    else $error("Memory skip mismatch");
  AST_BIT_SKIP: assert property (@(posedge CLK) disable iff (SRST)
    ctrl_go && ctrl_op == CFP_OP_BIT0_SKIP |-> alu_skip == !PWDATA[7])
    else $error("Bit clear skip mismatch");
  AST_IMM_REFUSE: assert property (@(posedge CLK) disable iff (SRST)
    s_imm_outside |=> PSLVERR)
    else $error("Immediate move outside window not refused");
  AST_RESTORE: assert property (@(posedge CLK) disable iff (SRST)
    s_restore |=> cur.acc == $past(cur.acc_save) && cur.flags[2:0] == $past(cur.flags_save[2:0]))
    else $error("Restore did not reload");
endmodule : cfp_core

// file: src/cfp_pkg.sv
package cfp_pkg;
  // ----------------------------------------
  // Register word addresses (APB byte addresses; printed offsets not all x4, so index*4)
  // ----------------------------------------
  localparam logic [7:0] CFP_IDX_LOOKUP = 8'h82;
  localparam logic [7:0] CFP_IDX_OFFSET_PTR = 8'h83;
  localparam logic [7:0] CFP_IDX_PAGE_PTR = 8'h84;
  localparam logic [7:0] CFP_IDX_FLAGS = 8'h86;
  localparam logic [7:0] CFP_IDX_PC_LOW = 8'hCE;
  localparam logic [7:0] CFP_IDX_PC_HIGH = 8'hCF;
  localparam logic [7:0] CFP_IDX_ACC = 8'h90;
  localparam logic [7:0] CFP_IDX_CTRL = 8'h91;
  localparam logic [7:0] CFP_IDX_OPERAND = 8'h92;
  localparam logic [7:0] CFP_IDX_ROM_ADDR = 8'h93;
  localparam logic [7:0] CFP_IDX_ROM_DATA = 8'h94;
  localparam logic [7:0] CFP_WREG_FIRST = 8'h80;
  localparam logic [7:0] CFP_WREG_LAST = 8'h87;
  // ----------------------------------------
  // Flag byte field positions and reset values
  // ----------------------------------------
  localparam int CFP_F_CAUSE_HI = 7;
  localparam int CFP_F_CAUSE_LO = 6;
  localparam int CFP_F_BROWN_HI = 5;
  localparam int CFP_F_BROWN_MID = 4;
  localparam int CFP_F_WRAP = 2;
  localparam int CFP_F_NIBBLE = 1;
  localparam int CFP_F_NULL = 0;
  localparam logic [1:0] CFP_CAUSE_WDT = 2'h0;
  localparam logic [1:0] CFP_CAUSE_RSVD = 2'h1;
  localparam logic [1:0] CFP_CAUSE_LVR = 2'h2;
  localparam logic [1:0] CFP_CAUSE_PIN = 2'h3;
  localparam logic [7:0] CFP_BYTE_RST = 8'h00;
  localparam logic [9:0] CFP_PC_RST = 10'h000;
  localparam logic [9:0] CFP_PC_STEP = 10'h001;
  localparam logic [9:0] CFP_PC_SKIP = 10'h002;
  // ----------------------------------------
  // Operations issued by the decoder
  // ----------------------------------------
  typedef enum logic [4:0] {
    CFP_OP_NONE = 5'b0_0000, CFP_OP_STEP = 5'b0_0001, CFP_OP_JUMP = 5'b0_0010,
    CFP_OP_CMP_SKIP = 5'b0_0011, CFP_OP_INC_ACC_SKIP = 5'b0_0100,
    CFP_OP_INC_MEM_SKIP = 5'b0_0101, CFP_OP_DEC_ACC_SKIP = 5'b0_0110,
    CFP_OP_DEC_MEM_SKIP = 5'b0_0111, CFP_OP_BIT0_SKIP = 5'b0_1000,
    CFP_OP_BIT1_SKIP = 5'b0_1001, CFP_OP_ADD = 5'b0_1010, CFP_OP_SUB = 5'b0_1011,
    CFP_OP_CMP = 5'b0_1100, CFP_OP_LOGIC = 5'b0_1101, CFP_OP_ROTATE = 5'b0_1110,
    CFP_OP_SAVE = 5'b0_1111, CFP_OP_RESTORE = 5'b1_0000, CFP_OP_TABLE = 5'b1_0001,
    CFP_OP_MOV_IMM = 5'b1_0010, CFP_OP_MOV_MEM = 5'b1_0011
  } cfp_op_t;
endpackage : cfp_pkg

// file: src/cfp_alu_flags.sv
`timescale 1ns/1ns
// Combinational carry / half-carry / zero / skip evaluation
module cfp_alu_flags
  import cfp_pkg::*;
(
  input wire cfp_op_t op,
  input wire logic [7:0] lhs,
  input wire logic [7:0] rhs,
  input wire logic carry_in,
  input wire logic use_carry,
  input wire logic rot_out,
  input wire logic test_bit,
  output logic [7:0] result,
  output logic wrap,
  output logic nibble,
  output logic null_res,
  output logic skip
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic cin;

  // ----------------------------------------
  // Arithmetic and condition decode
  // ----------------------------------------
  always_comb begin
    cin = use_carry & carry_in;
    sum = {1'b0, lhs} + {1'b0, rhs} + {8'h00, cin};
    low_sum = {1'b0, lhs[3:0]} + {1'b0, rhs[3:0]} + {4'h0, cin};
    diff = {1'b0, lhs} - {1'b0, rhs};
    low_diff = {1'b0, lhs[3:0]} - {1'b0, rhs[3:0]};
    result = lhs;
    wrap = carry_in;
    nibble = 1'b0;
    skip = 1'b0;
    case (op)
      CFP_OP_ADD: begin
        result = sum[7:0];
        wrap = sum[8];
        nibble = low_sum[4];
      end
      CFP_OP_SUB, CFP_OP_CMP: begin
        result = diff[7:0];
        wrap = ~diff[8];
        nibble = ~low_diff[4];
      end
      CFP_OP_ROTATE: wrap = rot_out;
      CFP_OP_LOGIC: result = lhs & rhs;
      CFP_OP_CMP_SKIP: begin
        result = diff[7:0];
        skip = (lhs == rhs);
      end
      CFP_OP_INC_ACC_SKIP, CFP_OP_INC_MEM_SKIP: begin
        result = lhs + 8'h01;
        skip = (lhs == 8'hFF);
      end
      CFP_OP_DEC_ACC_SKIP, CFP_OP_DEC_MEM_SKIP: begin
        result = lhs - 8'h01;
        skip = (lhs == 8'h00);
      end
      CFP_OP_BIT0_SKIP: skip = ~test_bit;
      CFP_OP_BIT1_SKIP: skip = test_bit;
      default: result = lhs;
    endcase
    null_res = (result == 8'h00);
  end
endmodule : cfp_alu_flags

// file: src/cfp_pc_unit.sv
`timescale 1ns/1ns
// Next program counter selection
module cfp_pc_unit
  import cfp_pkg::*;
(
  input wire logic [9:0] pc,
  input wire logic advance,
  input wire logic jump,
  input wire logic [9:0] target,
  input wire logic skip,
  input wire logic low_write,
  input wire logic [7:0] low_value,
  input wire logic low_add,
  input wire logic low_carry,
  output logic [9:0] next_pc
);
  // ----------------------------------------
  // Priority: jump, low-byte write, skip, step
  // ----------------------------------------
  always_comb begin
    next_pc = pc;
    if (jump) begin
      next_pc = target;
    end else if (low_write) begin
      // Only an add may carry into the high part; borrows are dropped
      next_pc = {pc[9:8] + {1'b0, low_add & low_carry}, low_value};
    end else if (advance && skip) begin
      next_pc = pc + CFP_PC_SKIP;
    end else if (advance) begin
      next_pc = pc + CFP_PC_STEP;
    end
  end
endmodule : cfp_pc_unit

// file: dv/cfp_rom_model.sv
`timescale 1ns/1ns
// Stand-in for program memory beside the core
module cfp_rom_model
  import cfp_pkg::*;
(
  input wire logic [9:0] addr,
  output logic [15:0] word
);
  // Both bytes differ and the low byte depends on all ten bits, so a swapped byte order shows up
  assign word = {~addr[7:0], addr[7:0] ^ {6'h00, addr[9:8]}};
endmodule : cfp_rom_model

// file: dv/core_flags_pc_and_pointers_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module core_flags_pc_and_pointers_bench
  import cfp_pkg::*;
;
  // ----------------------------------------
  // Stimulus state and instances
  // ----------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, er;
  logic opt = 1'b1;
  logic bhi = 1'b0;
  logic bmid = 1'b0;
  logic [1:0] cause = 2'h0;
  logic [15:0] ind, word;
  logic [9:0] fetch, rom_a;
  logic [9:0] exp_pc = 10'h000;
  logic [7:0] a, b, pg, of;
  logic [2:0] exp3;
  int fail_count = 0;
  int tests_run = 0;
  integer seed = 59465;
  cfp_op_t ar[3] = '{CFP_OP_ADD, CFP_OP_SUB, CFP_OP_CMP};

  cfp_core dut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RESET_CAUSE(cause), .LOW_VOLT_HIGH_OPTION(opt),
    .LOW_VOLT_MID_OPTION(opt), .SUPPLY_BELOW_HIGH(bhi), .SUPPLY_BELOW_MID(bmid),
    .INDIRECT_ADDR(ind), .FETCH_ADDR(fetch), .ROM_ADDR(rom_a));
  cfp_rom_model rom (.addr(rom_a), .word(word));

  // Core clock, 40 ns period
  always #20 clk = ~clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic test_done;
    $display("counts: %0d compares, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  function automatic logic [11:0] ad(logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ad

  function automatic logic [31:0] ctl(cfp_op_t op, logic [3:0] x, logic [7:0] imm);
    return {8'h00, imm, 7'h00, x, op};
  endfunction : ctl

  // Expected {carry, half carry, zero}; carry means no borrow when subtracting
  function automatic logic [2:0] arith(logic s, logic [7:0] x, logic [7:0] y);
    logic [8:0] r;
    logic [4:0] h;
    r = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    h = s ? {1'b0, x[3:0]} - {1'b0, y[3:0]} : {1'b0, x[3:0]} + {1'b0, y[3:0]};
    return {r[8] ^ s, h[4] ^ s, r[7:0] == 8'h00};
  endfunction : arith

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(logic w, logic [11:0] adr, logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= adr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fail_count++;
      test_done();
    end
  endtask : apb

  task automatic wr(logic [7:0] i, logic [7:0] d);
    apb(1'b1, ad(i), {24'h00_0000, d});
  endtask : wr

  task automatic rdr(logic [7:0] i);
    apb(1'b0, ad(i), 32'h0000_0000);
  endtask : rdr

  task automatic ctrl(cfp_op_t op, logic [3:0] x, logic [7:0] imm);
    apb(1'b1, ad(CFP_IDX_CTRL), ctl(op, x, imm));
  endtask : ctrl

  // Outputs are looked at mid-cycle so the write edge has fully landed
  task automatic chk_pc;
    @(negedge clk);
    `CHK(fetch, exp_pc)
  endtask : chk_pc

  task automatic jmp(logic [9:0] t);
    apb(1'b1, ad(CFP_IDX_ROM_ADDR), {22'h00_0000, t});
    ctrl(CFP_OP_JUMP, 4'h0, 8'h00);
    exp_pc = t;
    chk_pc();
  endtask : jmp

  task automatic sk(cfp_op_t o, logic [7:0] x, logic [7:0] m, logic t, logic s);
    wr(CFP_IDX_ACC, x);
    wr(CFP_IDX_OPERAND, m);
    ctrl(o, {1'b0, t, 2'b00}, 8'h00);
    exp_pc = exp_pc + (s ? CFP_PC_SKIP : CFP_PC_STEP);
    chk_pc();
  endtask : sk

  task automatic do_reset(logic [1:0] c);
    srst <= 1'b1;
    cause <= c;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
  endtask : do_reset

  task automatic note(string s);
    $display("test %s done", s);
  endtask : note

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    for (int c = 0; c < 4; c++) begin
      do_reset(c[1:0]);
      @(negedge clk);
      `CHK(fetch, CFP_PC_RST)
      rdr(CFP_IDX_FLAGS);
      `CHK(rdat[7:0], {c[1:0], 6'h00})
    end
    note("reset");
    // Supply comparators change at random; flags lag one cycle
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      bhi <= 1'($random(seed));
      bmid <= 1'($random(seed));
      repeat (2) @(posedge clk);
      rdr(CFP_IDX_FLAGS);
      `CHK(rdat[5], bhi)
      `CHK(rdat[4], bmid)
    end
    // With no option fitted the brownout flags stay clear whatever the supply does
    opt <= 1'b0;
    bhi <= 1'b1;
    bmid <= 1'b1;
    repeat (2) @(posedge clk);
    rdr(CFP_IDX_FLAGS);
    `CHK(rdat[5:4], 2'b00)
    opt <= 1'b1;
    wr(CFP_IDX_FLAGS, 8'hFF);
    rdr(CFP_IDX_FLAGS);
    `CHK(rdat[7:0], {2'b11, bhi, bmid, 4'b0111})
    note("flags");
    for (int i = 0; i < 6; i++) begin
      pg = 8'($random(seed));
      of = 8'($random(seed));
      wr(CFP_IDX_PAGE_PTR, pg);
      wr(CFP_IDX_OFFSET_PTR, of);
      @(negedge clk);
      `CHK(ind, {pg, of})
      `CHK(rom_a, {pg[1:0], of})
      rdr(CFP_IDX_PAGE_PTR);
      `CHK(rdat[7:0], pg)
      apb(1'b1, ad(CFP_IDX_ROM_DATA), {16'h0000, word});
      ctrl(CFP_OP_TABLE, 4'h0, 8'h00);
      rdr(CFP_IDX_LOOKUP);
      `CHK(rdat[7:0], word[15:8])
      rdr(CFP_IDX_ACC);
      `CHK(rdat[7:0], word[7:0])
    end
    note("pointers");
    // First two passes are hand corners: zero sum with carry, equal operands
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 8'h80 : 8'($random(seed));
      b = (i == 0) ? 8'h80 : (i == 1) ? a : 8'($random(seed));
      wr(CFP_IDX_ACC, a);
      wr(CFP_IDX_OPERAND, b);
      ctrl(ar[i % 3], 4'h0, 8'h00);
      exp3 = arith(i % 3 != 0, a, b);
      rdr(CFP_IDX_FLAGS);
      `CHK(rdat[2], exp3[2])
      `CHK(rdat[0], exp3[0])
      if (i % 3 != 2) `CHK(rdat[1], exp3[1])
    end
    for (int r = 0; r < 2; r++) begin
      ctrl(CFP_OP_ROTATE, {2'b00, r[0], 1'b0}, 8'h00);
      rdr(CFP_IDX_FLAGS);
      `CHK(rdat[2], r[0])
    end
    // Logic results, the first pass forced to zero
    for (int i = 0; i < 4; i++) begin
      a = 8'($random(seed));
      b = (i == 0) ? ~a : 8'($random(seed));
      wr(CFP_IDX_ACC, a);
      wr(CFP_IDX_OPERAND, b);
      ctrl(CFP_OP_LOGIC, 4'h0, 8'h00);
      rdr(CFP_IDX_FLAGS);
      `CHK(rdat[0], (a & b) == 8'h00)
    end
    note("arith");
    wr(CFP_IDX_ACC, 8'h01);
    wr(CFP_IDX_OPERAND, 8'hFF);
    ctrl(CFP_OP_ADD, 4'h0, 8'h00);
    wr(CFP_IDX_ACC, 8'h3C);
    ctrl(CFP_OP_SAVE, 4'h0, 8'h00);
    wr(CFP_IDX_ACC, 8'h00);
    wr(CFP_IDX_FLAGS, 8'h00);
    ctrl(CFP_OP_RESTORE, 4'h0, 8'h00);
    rdr(CFP_IDX_ACC);
    `CHK(rdat[7:0], 8'h3C)
    rdr(CFP_IDX_FLAGS);
    `CHK(rdat[2:0], 3'b111)
    note("save");
    // Counter wraps at ten bits; low-byte add carries up, borrow does not
    jmp(10'h3FF);
    ctrl(CFP_OP_STEP, 4'h0, 8'h00);
    exp_pc = 10'h000;
    chk_pc();
    jmp(10'h1F0);
    wr(CFP_IDX_ACC, 8'h20);
    ctrl(CFP_OP_ADD, 4'h8, 8'h00);
    exp_pc = 10'h210;
    chk_pc();
    ctrl(CFP_OP_SUB, 4'h8, 8'h00);
    exp_pc = 10'h2F0;
    chk_pc();
    jmp(10'h323);
    wr(CFP_IDX_PC_LOW, 8'h28);
    exp_pc = 10'h328;
    chk_pc();
    wr(CFP_IDX_PC_LOW, 8'h00);
    exp_pc = 10'h300;
    chk_pc();
    rdr(CFP_IDX_PC_HIGH);
    `CHK(rdat[1:0], 2'h3)
    sk(CFP_OP_CMP_SKIP, 8'h5A, 8'h5A, 1'b0, 1'b1);
    sk(CFP_OP_CMP_SKIP, 8'h5A, 8'h5B, 1'b0, 1'b0);
    sk(CFP_OP_INC_ACC_SKIP, 8'hFF, 8'h00, 1'b0, 1'b1);
    sk(CFP_OP_INC_ACC_SKIP, 8'hFE, 8'hFF, 1'b0, 1'b0);
    sk(CFP_OP_INC_MEM_SKIP, 8'h00, 8'hFF, 1'b0, 1'b1);
    sk(CFP_OP_INC_MEM_SKIP, 8'hFF, 8'hFE, 1'b0, 1'b0);
    sk(CFP_OP_DEC_ACC_SKIP, 8'h00, 8'h01, 1'b0, 1'b1);
    sk(CFP_OP_DEC_ACC_SKIP, 8'h01, 8'h00, 1'b0, 1'b0);
    sk(CFP_OP_DEC_MEM_SKIP, 8'h01, 8'h00, 1'b0, 1'b1);
    sk(CFP_OP_DEC_MEM_SKIP, 8'h00, 8'h01, 1'b0, 1'b0);
    sk(CFP_OP_BIT0_SKIP, 8'h00, 8'h00, 1'b0, 1'b1);
    sk(CFP_OP_BIT0_SKIP, 8'h00, 8'h00, 1'b1, 1'b0);
    sk(CFP_OP_BIT1_SKIP, 8'h00, 8'h00, 1'b1, 1'b1);
    sk(CFP_OP_BIT1_SKIP, 8'h00, 8'h00, 1'b0, 1'b0);
    note("counter");
    wr(CFP_IDX_OPERAND, CFP_IDX_LOOKUP);
    ctrl(CFP_OP_MOV_IMM, 4'h0, 8'hA5);
    `CHK(er, 1'b0)
    wr(CFP_IDX_OPERAND, 8'h88);
    ctrl(CFP_OP_MOV_IMM, 4'h0, 8'h5A);
    `CHK(er, 1'b1)
    rdr(CFP_IDX_LOOKUP);
    `CHK(rdat[7:0], 8'hA5)
    // A hole in the map must refuse and return zero
    apb(1'b0, 12'h214, 32'h0000_0000);
    `CHK({er, rdat}, {1'b1, 32'h0000_0000})
    // A misaligned write must be refused and leave the register alone
    apb(1'b1, ad(CFP_IDX_LOOKUP) | 12'h001, 32'h0000_0033);
    `CHK(er, 1'b1)
    rdr(CFP_IDX_LOOKUP);
    `CHK(rdat[7:0], 8'hA5)
    note("refusals");
    test_done();
  end
endmodule : core_flags_pc_and_pointers_bench
